// *** srs_partner_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// processor, clock synthesizer and supply stand-in
// ************************************************************
module srs_partner_model #(
    parameter int PG_DLY = 500 // power good delay, shortened
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // sequencer side
    input wire srs_pkg::srs_pins_t pins,
    input wire logic clock_halt_oe,
    // bench controls
    input wire logic cut_power,
    input wire logic [11:0] grant_dly,
    // answers
    output logic stop_grant_done = 1'b0,
    output logic core_power_good = 1'b1,
    output logic clocks_running = 1'b1
);
    int gcnt = 0;
    int pcnt = 0;
    logic halted_d = 1'b0;
    logic halted;
    assign halted = clock_halt_oe & ~pins.cpu_clock_halt_n
        & ~pins.bus_clock_halt_n;
    // stop-grant cycle some cycles after the stop-clock request
    always @(negedge clk_sys) begin
        stop_grant_done <= 1'b0;
        if (pins.stop_clock_request_n) begin
            gcnt <= 0;
        end else if (gcnt == int'(grant_dly)) begin
            stop_grant_done <= 1'b1;
            gcnt <= gcnt + 1;
        end else if (gcnt < int'(grant_dly)) begin
            gcnt <= gcnt + 1;
        end
    end
    // supply: good drops on a cut, returns late once the well is on
    always @(negedge clk_sys) begin
        if (cut_power) begin
            core_power_good <= 1'b0;
            pcnt <= 0;
        end else if (!core_power_good && pins.power_plane_off_n[1]) begin
            pcnt <= pcnt + 1;
            if (pcnt >= PG_DLY) begin
                core_power_good <= 1'b1;
            end
        end
    end
    // synthesizer stops two edges after halts, restarts after one
    always @(negedge clk_sys) begin
        halted_d <= halted;
        clocks_running <= ~(halted & halted_d);
    end
endmodule // srs_partner_model

// *** srs_pkg.sv ***
package srs_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned RTC_TICK_NS = 32000;
    localparam int unsigned PLL_WAIT_MS = 16;
    localparam int unsigned STAT_WAIT_MS = 1;
    localparam int unsigned NS_PER_MS = 1000000;
    // cycles per rtc tick, rounded up
    localparam int unsigned TICK_CYC =
        (RTC_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // least waits in ticks, rounded up
    localparam int unsigned PLL_WAIT_TICKS =
        (PLL_WAIT_MS * NS_PER_MS + RTC_TICK_NS - 1) / RTC_TICK_NS;
    localparam int unsigned STAT_WAIT_TICKS =
        (STAT_WAIT_MS * NS_PER_MS + RTC_TICK_NS - 1) / RTC_TICK_NS;
    localparam int DIV_W = 12;
    localparam int CNT_W = 10;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        SRS_RES_FULL = 2'h0,
        SRS_RES_CPU = 2'h1,
        SRS_RES_NONE = 2'h2
    } srs_rtype_t;

    typedef enum logic [3:0] {
        SRS_ON = 4'h0, SRS_E_STOP = 4'h1, SRS_E_SLEEP = 4'h3,
        SRS_E_STAT = 4'h2, SRS_E_HALT = 4'h6, SRS_E_PLANE = 4'h7,
        SRS_SUSP = 4'h5, SRS_R_WAKE = 4'h4, SRS_R_PLL = 4'hc,
        SRS_R_STAT = 4'hd, SRS_R_BUS = 4'hf, SRS_R_CPU = 4'he
    } srs_state_t;

    typedef struct packed {
        logic stop_clock_request_n;
        logic cpu_sleep_n;
        logic suspend_status_n;
        logic cpu_clock_halt_n;
        logic bus_clock_halt_n;
        logic [2:0] power_plane_off_n;
        logic bus_reset;
        logic processor_reset;
    } srs_pins_t;

    // ************************************************************
    // reset and plane values
    // ************************************************************
    localparam logic [2:0] PLANES_OFF = 3'h7;
    localparam logic [2:0] PLANES_POS = 3'h6;
    localparam logic [2:0] PLANES_STR = 3'h4;
    localparam srs_pins_t PINS_RST =
        '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, PLANES_OFF, 1'b0, 1'b0};
endpackage

// *** srs_sequencer.sv ***
`timescale 1ns/1ps
// Contract
// [R1] stop-clock request one tick after halts inactive
// [R2] sleep one tick after stop-clock, after grant
// [R3] status then halts, each within a tick
// [R4] halts active only under clock control; code drives them active in ram resume regardless of clock_control_en
// [R5] power on suspend drives only plane zero
// [R6] synthesizer stops clocks within two bus clocks
// [R7] full resume: plane off, resets, wake cpu
// [R8] halts released after 16 ms and power good
// [R9] synthesizer restarts clocks within two bus clocks
// [R10] status held 1 ms after halts released
// [R11] full resume: bus then processor reset release
// [R12] cpu-only resume: processor reset only
// [R13] no-reset resume: release sleep then stop-clock
// [R14] suspend to ram drives planes zero and one
// [R15] power loss: float halts, resets, wake cpu
// [R16] ram suspend holds outputs while powered
// [R17] supply holds power good 1 ms; code only needs power good still high at the next rtc tick
// [R18] ram resume: planes off one tick later
// [R19] ram resume: halts active on power good
// [R20] ram resume: bus reset, then processor reset
// [R21] steps timed by 32 us rtc tick
// [R22] one tick-driven machine, paths by mode
module srs_sequencer #(
    parameter int unsigned P_PLL_TICKS = srs_pkg::PLL_WAIT_TICKS,
    parameter int unsigned P_STAT_TICKS = srs_pkg::STAT_WAIT_TICKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // sequencing requests
    input wire logic suspend_req,
    input wire logic suspend_to_ram,
    input wire logic resume_event,
    input wire srs_pkg::srs_rtype_t resume_type,
    input wire logic clock_control_en,
    input wire logic stop_grant_done,
    // power status pin
    input wire logic core_power_good,
    // sequenced outputs
    output srs_pkg::srs_pins_t pins,
    output logic clock_halt_oe
);
    // ************************************************************
    // power good synchroniser
    // ************************************************************
    logic pg_meta_reg;
    logic pg_reg;

    // two flops on the pin
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pg_meta_reg <= 1'b0;
            pg_reg <= 1'b0;
        end else begin
            pg_meta_reg <= core_power_good;
            pg_reg <= pg_meta_reg;
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    srs_pkg::srs_state_t st_reg, st_next;
    srs_pkg::srs_pins_t out_reg, out_next;
    srs_pkg::srs_rtype_t rt_reg, rt_next;
    logic str_reg, str_next;
    logic grant_reg, grant_next;
    logic pgh_reg, pgh_next;
    logic [srs_pkg::DIV_W-1:0] div_reg, div_next;
    logic [srs_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic tick;
    logic pll_done;
    logic stat_done;

    // rtc tick restarts on each state change
    assign tick = (div_reg == srs_pkg::DIV_W'(srs_pkg::TICK_CYC - 1)); // [R21]
    assign pll_done = (cnt_reg >= srs_pkg::CNT_W'(P_PLL_TICKS));
    assign stat_done = (cnt_reg >= srs_pkg::CNT_W'(P_STAT_TICKS));

    // next state and outputs
    always_comb begin
        st_next = st_reg;
        out_next = out_reg;
        rt_next = rt_reg;
        str_next = str_reg;
        grant_next = grant_reg | stop_grant_done;
        pgh_next = pg_reg & (pgh_reg | tick); // [R17]
        cnt_next = cnt_reg;
        if (tick && (cnt_reg != '1)) begin
            cnt_next = cnt_reg + 1'b1;
        end
        unique case (st_reg) // [R22]
            srs_pkg::SRS_ON: begin
                grant_next = stop_grant_done;
                if (suspend_req) begin
                    str_next = suspend_to_ram;
                    st_next = srs_pkg::SRS_E_STOP;
                end
            end
            srs_pkg::SRS_E_STOP: begin
                if (tick) begin
                    out_next.stop_clock_request_n = 1'b0; // [R1]
                    st_next = srs_pkg::SRS_E_SLEEP;
                end
            end
            srs_pkg::SRS_E_SLEEP: begin
                if (tick && grant_reg) begin
                    out_next.cpu_sleep_n = 1'b0; // [R2]
                    st_next = srs_pkg::SRS_E_STAT;
                end
            end
            srs_pkg::SRS_E_STAT: begin
                if (tick) begin
                    out_next.suspend_status_n = 1'b0; // [R3]
                    st_next = srs_pkg::SRS_E_HALT;
                end
            end
            srs_pkg::SRS_E_HALT: begin
                if (tick) begin
                    out_next.cpu_clock_halt_n = !clock_control_en; // [R4]
                    out_next.bus_clock_halt_n = !clock_control_en; // [R4]
                    st_next = srs_pkg::SRS_E_PLANE;
                end
            end
            srs_pkg::SRS_E_PLANE: begin
                if (tick) begin
                    out_next.power_plane_off_n = str_reg ?
                        srs_pkg::PLANES_STR : // [R14]
                        srs_pkg::PLANES_POS; // [R5]
                    st_next = srs_pkg::SRS_SUSP;
                end
            end
            srs_pkg::SRS_SUSP: begin
                // outputs hold here while powered
                if (resume_event) begin // [R16]
                    rt_next = str_reg ? srs_pkg::SRS_RES_FULL : resume_type;
                    st_next = srs_pkg::SRS_R_WAKE;
                end
            end
            srs_pkg::SRS_R_WAKE: begin
                if (tick) begin
                    out_next.power_plane_off_n = srs_pkg::PLANES_OFF; // [R7] [R18]
                    if (rt_reg != srs_pkg::SRS_RES_NONE) begin
                        out_next.processor_reset = 1'b1; // [R7] [R12]
                        out_next.cpu_sleep_n = 1'b1;
                        out_next.stop_clock_request_n = 1'b1;
                    end
                    if (rt_reg == srs_pkg::SRS_RES_FULL) begin
                        out_next.bus_reset = 1'b1; // [R7]
                    end
                    st_next = srs_pkg::SRS_R_PLL;
                end
            end
            srs_pkg::SRS_R_PLL: begin
                if (str_reg && pg_reg && !pgh_reg) begin
                    out_next.cpu_clock_halt_n = 1'b0; // [R19]
                    out_next.bus_clock_halt_n = 1'b0; // [R19]
                end
                if (tick && pll_done && pgh_reg) begin
                    out_next.cpu_clock_halt_n = 1'b1; // [R8] [R19]
                    out_next.bus_clock_halt_n = 1'b1; // [R8] [R19]
                    st_next = srs_pkg::SRS_R_STAT;
                end
            end
            srs_pkg::SRS_R_STAT: begin
                if (tick && stat_done) begin
                    out_next.suspend_status_n = 1'b1; // [R10]
                    st_next = srs_pkg::SRS_R_BUS;
                end
            end
            srs_pkg::SRS_R_BUS: begin
                if (tick) begin
                    unique case (rt_reg)
                        srs_pkg::SRS_RES_FULL:
                            out_next.bus_reset = 1'b0; // [R11] [R20]
                        srs_pkg::SRS_RES_CPU:
                            out_next.processor_reset = 1'b0; // [R12]
                        default:
                            out_next.cpu_sleep_n = 1'b1; // [R13]
                    endcase
                    st_next = srs_pkg::SRS_R_CPU;
                end
            end
            srs_pkg::SRS_R_CPU: begin
                if (tick) begin
                    out_next.processor_reset = 1'b0; // [R11] [R20]
                    out_next.cpu_sleep_n = 1'b1;
                    out_next.stop_clock_request_n = 1'b1; // [R13]
                    st_next = srs_pkg::SRS_ON;
                end
            end
            default: begin
                out_next = srs_pkg::PINS_RST;
                st_next = srs_pkg::SRS_ON;
            end
        endcase
        // power loss outside on: resets and wake cpu
        if (!pg_reg && (st_reg != srs_pkg::SRS_ON)) begin
            out_next.bus_reset = 1'b1; // [R15]
            out_next.processor_reset = 1'b1; // [R15]
            out_next.cpu_sleep_n = 1'b1; // [R15]
            out_next.stop_clock_request_n = 1'b1; // [R15]
            rt_next = srs_pkg::SRS_RES_FULL;
        end
        if (st_next != st_reg) begin
            cnt_next = '0;
        end
    end

    // divider restarts with each step
    always_comb begin
        if (tick || (st_next != st_reg)) begin
            div_next = '0;
        end else begin
            div_next = div_reg + 1'b1;
        end
    end

    // state registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg <= srs_pkg::SRS_ON;
            out_reg <= srs_pkg::PINS_RST;
            rt_reg <= srs_pkg::SRS_RES_FULL;
            str_reg <= 1'b0;
            grant_reg <= 1'b0;
            pgh_reg <= 1'b0;
            div_reg <= '0;
            cnt_reg <= '0;
        end else begin
            st_reg <= st_next;
            out_reg <= out_next;
            rt_reg <= rt_next;
            str_reg <= str_next;
            grant_reg <= grant_next;
            pgh_reg <= pgh_next;
            div_reg <= div_next;
            cnt_reg <= cnt_next;
        end
    end

    // outputs; halts float without power good
    assign pins = out_reg;
    assign clock_halt_oe = pg_reg; // [R15]

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    AST_STOP_AFTER_HALTS: assert property ( // [R1]
        $fell(pins.stop_clock_request_n) |->
            pins.cpu_clock_halt_n && pins.bus_clock_halt_n)
        else $error("stop-clock while halts active");
    AST_SLEEP_AFTER_GRANT: assert property ( // [R2]
        $fell(pins.cpu_sleep_n) |->
            $past(grant_reg) && $past(!pins.stop_clock_request_n))
        else $error("sleep before grant or stop-clock");
    AST_STAT_AFTER_SLEEP: assert property ( // [R3]
        $fell(pins.suspend_status_n) |-> !pins.cpu_sleep_n)
        else $error("status before sleep");
    AST_HALT_GATED: assert property ( // [R4]
        (st_reg == srs_pkg::SRS_E_HALT && tick && !clock_control_en)
        |=> pins.cpu_clock_halt_n && pins.bus_clock_halt_n)
        else $error("halt without clock control");
    AST_POS_ONE_PLANE: assert property ( // [R5]
        $fell(pins.power_plane_off_n[0]) && !str_reg |->
            pins.power_plane_off_n[2:1] == 2'h3)
        else $error("extra plane in power on suspend");
    AST_HALT_RELEASE: assert property ( // [R8]
        (st_reg == srs_pkg::SRS_R_PLL) ##1 $rose(pins.cpu_clock_halt_n)
        |-> $past(pll_done) && $past(pgh_reg))
        else $error("halt released early");
    AST_STAT_HOLD: assert property ( // [R10]
        $rose(pins.suspend_status_n) |-> $past(stat_done))
        else $error("status released early");
    AST_CPU_ONLY: assert property ( // [R12]
        (st_reg == srs_pkg::SRS_R_WAKE && tick && pg_reg &&
         rt_reg == srs_pkg::SRS_RES_CPU)
        |=> pins.processor_reset && !pins.bus_reset)
        else $error("cpu-only resume reset wrong");
    AST_POWER_LOSS: assert property ( // [R15]
        $fell(pg_reg) && st_reg != srs_pkg::SRS_ON |=>
            !clock_halt_oe && pins.bus_reset && pins.processor_reset)
        else $error("power loss not handled");

    CVR_POS: cover property (
        !str_reg && $fell(pins.power_plane_off_n[0]));
    CVR_STR: cover property (str_reg && $fell(pins.power_plane_off_n[1]));
    CVR_RESUME_DONE: cover property (
        st_reg == srs_pkg::SRS_R_CPU ##1 st_reg == srs_pkg::SRS_ON);
endmodule // srs_sequencer

// *** suspend_resume_sequencer_tb_top.sv ***
`timescale 1ns/1ps
// ************************************************************
// bench
// ************************************************************
module suspend_resume_sequencer_tb_top;
    localparam int TK = srs_pkg::TICK_CYC;
    // short waits keep the run under the cycle budget
    localparam int PLL = 1;
    localparam int STA = 1;
    localparam int PGD = 500;
    logic clk_sys, nrst, suspend_req, suspend_to_ram, resume_event;
    logic clock_control_en, stop_grant_done, core_power_good;
    logic clock_halt_oe, cut_power, clocks_running;
    logic [11:0] grant_dly;
    srs_pkg::srs_rtype_t resume_type, rt;
    srs_pkg::srs_pins_t pins, exp_pins, last_pins;
    int err_count, total_checks, cyc, t_off;

    srs_sequencer #(.P_PLL_TICKS(PLL), .P_STAT_TICKS(STA)) DUT (
        .clk_sys(clk_sys), .nrst(nrst), .suspend_req(suspend_req),
        .suspend_to_ram(suspend_to_ram), .resume_event(resume_event),
        .resume_type(resume_type), .clock_control_en(clock_control_en),
        .stop_grant_done(stop_grant_done),
        .core_power_good(core_power_good), .pins(pins),
        .clock_halt_oe(clock_halt_oe));
    srs_partner_model #(.PG_DLY(PGD)) u_partner (
        .clk_sys(clk_sys), .nrst(nrst), .pins(pins),
        .clock_halt_oe(clock_halt_oe), .cut_power(cut_power),
        .grant_dly(grant_dly), .stop_grant_done(stop_grant_done),
        .core_power_good(core_power_good),
        .clocks_running(clocks_running));

    // clock and cycle count
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial cyc = 0;
    always @(negedge clk_sys) cyc <= cyc + 1;

    task automatic final_report();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    // floated halts read as the board pull-up
    function automatic srs_pkg::srs_pins_t seen();
        srs_pkg::srs_pins_t v;
        v = pins;
        if (clock_halt_oe !== 1'b1) begin
            v.cpu_clock_halt_n = 1'b1;
            v.bus_clock_halt_n = 1'b1;
        end
        return v;
    endfunction

    // wait for the next output change and check value and delay
    task automatic step(input int lo, input int hi);
        int n;
        n = 0;
        while (seen() === last_pins && n <= hi) begin
            @(negedge clk_sys);
            n++;
        end
        check_val(32'(seen()), 32'(exp_pins));
        check_val(32'(n >= lo && n <= hi), 32'h1);
        last_pins = seen();
        if (n > hi) final_report();
    endtask

    task automatic entry(input logic ram, input logic cc);
        grant_dly = 12'($urandom_range(1, 3000));
        suspend_to_ram = ram;
        clock_control_en = cc;
        repeat ($urandom_range(1, 20)) @(negedge clk_sys);
        suspend_req = 1'b1;
        @(negedge clk_sys) suspend_req = 1'b0;
        exp_pins.stop_clock_request_n = 1'b0;
        step(TK - 3, TK + 3);
        exp_pins.cpu_sleep_n = 1'b0;
        step(TK - 3, TK + 3);
        exp_pins.suspend_status_n = 1'b0;
        step(TK - 3, TK + 3);
    endtask

    task automatic resume(input srs_pkg::srs_rtype_t rt);
        resume_type = rt;
        resume_event = 1'b1;
        @(negedge clk_sys) resume_event = 1'b0;
    endtask

    // main sequence
    initial begin
        void'($urandom(32'h750509db));
        err_count = 0;
        total_checks = 0;
        {suspend_req, suspend_to_ram, resume_event, cut_power} = 4'h0;
        clock_control_en = 1'b1;
        resume_type = srs_pkg::SRS_RES_FULL;
        grant_dly = 12'h0010;
        nrst = 1'b0;
        repeat (2) @(negedge clk_sys);
        nrst = 1'b1;
        exp_pins = srs_pkg::PINS_RST;
        last_pins = srs_pkg::PINS_RST;
        // a resume event while on is ignored
        resume(srs_pkg::SRS_RES_FULL);
        repeat (TK + 10) @(negedge clk_sys);
        check_val(32'(seen()), 32'(exp_pins));
        // power on suspend under clock control, resume of random type
        entry(1'b0, 1'b1);
        exp_pins.cpu_clock_halt_n = 1'b0;
        exp_pins.bus_clock_halt_n = 1'b0;
        step(TK - 3, TK + 3);
        exp_pins.power_plane_off_n = srs_pkg::PLANES_POS;
        step(TK - 3, TK + 3);
        suspend_req = 1'b1;
        @(negedge clk_sys) suspend_req = 1'b0;
        // resume type drawn at random: full, cpu only or none
        rt = srs_pkg::srs_rtype_t'($urandom_range(0, 2));
        resume(rt);
        exp_pins = srs_pkg::PINS_RST;
        exp_pins.cpu_clock_halt_n = 1'b0;
        exp_pins.bus_clock_halt_n = 1'b0;
        exp_pins.suspend_status_n = 1'b0;
        if (rt == srs_pkg::SRS_RES_NONE) begin
            exp_pins.stop_clock_request_n = 1'b0;
            exp_pins.cpu_sleep_n = 1'b0;
        end else begin
            exp_pins.processor_reset = 1'b1;
            exp_pins.bus_reset = (rt == srs_pkg::SRS_RES_FULL);
        end
        step(TK - 3, TK + 3);
        exp_pins.cpu_clock_halt_n = 1'b1;
        exp_pins.bus_clock_halt_n = 1'b1;
        step(PLL * TK - 3, (PLL + 3) * TK);
        exp_pins.suspend_status_n = 1'b1;
        step(STA * TK - 3, (STA + 1) * TK + 3);
        if (rt == srs_pkg::SRS_RES_FULL) begin
            exp_pins.bus_reset = 1'b0;
            step(1, TK + 3);
            exp_pins.processor_reset = 1'b0;
            step(1, TK + 3);
        end else if (rt == srs_pkg::SRS_RES_CPU) begin
            exp_pins.processor_reset = 1'b0;
            step(1, 2 * TK + 3);
            // last step changes nothing; let the machine reach on
            repeat (TK + 5) @(negedge clk_sys);
        end else begin
            exp_pins.cpu_sleep_n = 1'b1;
            step(1, TK + 3);
            exp_pins.stop_clock_request_n = 1'b1;
            step(TK - 3, TK + 3);
        end
        // suspend to ram without clock control, then power loss
        entry(1'b1, 1'b0);
        exp_pins.power_plane_off_n = srs_pkg::PLANES_STR;
        step(2 * TK - 3, 2 * TK + 3);
        clock_control_en = 1'b1;
        repeat (TK) @(negedge clk_sys);
        check_val(32'(seen()), 32'(exp_pins));
        cut_power = 1'b1;
        @(negedge clk_sys) cut_power = 1'b0;
        exp_pins.bus_reset = 1'b1;
        exp_pins.processor_reset = 1'b1;
        exp_pins.cpu_sleep_n = 1'b1;
        exp_pins.stop_clock_request_n = 1'b1;
        step(1, TK + 3);
        check_val(32'(clock_halt_oe), 32'h0);
        resume(srs_pkg::srs_rtype_t'($urandom_range(0, 2)));
        exp_pins.power_plane_off_n = srs_pkg::PLANES_OFF;
        step(TK - 3, TK + 3);
        t_off = cyc;
        exp_pins.cpu_clock_halt_n = 1'b0;
        exp_pins.bus_clock_halt_n = 1'b0;
        step(PGD, PGD + 10);
        check_val(32'(clock_halt_oe), 32'h1);
        exp_pins.cpu_clock_halt_n = 1'b1;
        exp_pins.bus_clock_halt_n = 1'b1;
        step(TK - 3, (PLL + 3) * TK);
        check_val(32'(cyc - t_off >= PLL * TK), 32'h1);
        exp_pins.suspend_status_n = 1'b1;
        step(STA * TK - 3, (STA + 1) * TK + 3);
        exp_pins.bus_reset = 1'b0;
        step(TK - 3, TK + 3);
        exp_pins.processor_reset = 1'b0;
        step(TK - 3, TK + 3);
        final_report();
    end
endmodule // suspend_resume_sequencer_tb_top
